// >>> adc_serial_result_port_test.sv
// self-checking bench of the serial result port with a host model
`timescale 1ns/1ps
module adc_serial_result_port_test;
	logic                      clock = 1'b0;
	logic                      rst = 1'b1;
	asrp_pkg::asrp_link_type   link;
	asrp_pkg::asrp_result_type result = '0;
	logic                      result_valid = 1'b0;
	logic                      sdo;
	logic                      sdo_oe;
	logic                      power_down;
	logic                      conv_tick;
	logic                      result_ready;
	wire                       sdo_w;
	int                        error_cnt = 0;
	int                        n_tests = 0;
	int                        seed = 71;
	int                        ticks = 0;
	int                        k;
	int                        nb;
	logic [31:0]               r;
	logic [11:0]               q[$];
	logic [15:0]               rx;
	logic [15:0]               expv;
	// mode 2 must follow a frame that left chip select low;
	// mode 3 is a chip select frame cut after eight clocks
	int                        modes[8] = '{3, 0, 1, 2, 2, 1, 2, 0};

	always #25 clock = ~clock;
	assign sdo_w = sdo_oe ? sdo : 1'bz;
	always @(posedge clock) if (conv_tick === 1'b1) ticks++;

	asrp_port i_asrp_port (
		.clock        (clock),
		.rst          (rst),
		.link         (link),
		.sdo          (sdo),
		.sdo_oe       (sdo_oe),
		.power_down   (power_down),
		.conv_tick    (conv_tick),
		.result       (result),
		.result_valid (result_valid),
		.result_ready (result_ready)
	);

	asrp_host i_asrp_host (
		.sdo_w (sdo_w),
		.link  (link)
	);

	// ------------------------------------------------------------
	// checking and closing
	// ------------------------------------------------------------
	task automatic wrap_up();
		$display("errors %0d of %0d checks", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t: word got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t: flag got %b exp %b", $time, got, exp);
		end
	endtask

	// valid stays up after the push; caller lowers it
	task automatic push(input logic [11:0] w);
		int i;
		result <= '{code: w};
		result_valid <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge clock);
			if (result_ready === 1'b1)
				break;
		end
		if (i == 40) begin
			error_cnt++;
			wrap_up();
		end
		q.push_back(w);
	endtask

	initial begin
		#500000;
		error_cnt++;
		wrap_up();
	end

	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		// full-scale and zero codes pass unchanged, then fill the buffer
		push(12'hfff);
		push(12'h000);
		r = $random(seed);
		push(r[11:0]);
		r = $random(seed);
		push(r[11:0]);
		// a word offered while full must not be taken
		result <= '{code: 12'h777};
		repeat (4) @(posedge clock);
		result_valid <= 1'b0;
		@(negedge clock);
		cmp1(result_ready, 1'b0);
		for (k = 0; k < 8; k++) begin
			if (k >= 5) begin
				@(posedge clock);
				r = $random(seed);
				push(r[11:0]);
				// lowered in the handshake step so the word goes in once
				result_valid <= 1'b0;
			end
			@(negedge clock);
			cmp1(sdo_oe, 1'b0);
			cmp1(power_down, 1'b1);
			ticks = 0;
			nb = (modes[k] == 3) ? 8 : 16;
			expv = {(q.size() > 0) ? q.pop_front() : 12'h000, 4'h0};
			fork
				i_asrp_host.frame(modes[k], rx);
				begin
					repeat (60) @(posedge clock);
					@(negedge clock);
					cmp1(power_down, 1'b0);
					cmp1(sdo_oe, 1'b1);
				end
			join
			@(negedge clock);
			cmp16(rx, expv >> (16 - nb));
			cmp16(16'(ticks), 16'(nb));
			cmp1(sdo_oe, 1'b0);
			cmp1(power_down, 1'b1);
		end
		wrap_up();
	end
endmodule

// >>> asrp_fifo.sv
// small result buffer with valid/ready on both sides
`timescale 1ns/1ps
module asrp_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 4
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	// depth must be a power of two so the pointers wrap by themselves
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	// ----------------------------------------------------------------
	// next values
	// ----------------------------------------------------------------
	always_comb begin
		push        = in_valid && in_ready;
		pop         = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	assign out_data = mem[rd_ptr];

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			wr_ptr    <= next_wr_ptr;
			rd_ptr    <= next_rd_ptr;
			count     <= next_count;
			in_ready  <= next_count != (AW+1)'(DEPTH);
			out_valid <= next_count != '0;
		end
	end

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

endmodule

// >>> asrp_host.sv
// host serial port model: drives the framing pins, samples data on falls
`timescale 1ns/1ps
module asrp_host (
	input  wire logic               sdo_w,
	output asrp_pkg::asrp_link_type link
);
	localparam int HALF = 200;

	initial link = '{1'b1, 1'b1, 1'b0};

	task automatic pulse();
		#HALF link.sclk = 1'b1;
		#HALF link.sclk = 1'b0;
	endtask

	// ------------------------------------------------------------
	// mode 0: chip select only, 1: cs then frame sync, 2: fs only,
	// 3: chip select frame cut after eight clocks
	// ------------------------------------------------------------
	// framed sixteen falls, eight in mode 3
	task automatic frame(input int mode, output logic [15:0] rx);
		int   i;
		int   n;
		logic cs_only;
		cs_only = (mode == 0 || mode == 3);
		n = (mode == 3) ? 8 : 16;
		rx = 16'h0000;
		if (mode != 2)
			link.cs_n = 1'b1;
		link.frame_sync = cs_only;
		pulse();
		#HALF;
		if (mode == 2)
			link.frame_sync = 1'b1;
		else
			link.cs_n = 1'b0;
		if (!cs_only) begin
			#HALF;
			link.frame_sync = 1'b1;
			pulse();
			// fs stays high past that fall so the port skips it
			#HALF link.frame_sync = 1'b0;
		end
		#HALF;
		for (i = 0; i < n; i++) begin
			#HALF link.sclk = 1'b1;
			#HALF link.sclk = 1'b0;
			rx = {rx[14:0], sdo_w};
		end
		// cut frame: chip select rises half a clock after the last fall
		if (mode == 3) begin
			#HALF link.cs_n = 1'b1;
		end
		#(2 * HALF);
	endtask
endmodule

// >>> asrp_pkg.sv
// shared constants, carriers and states of the serial result port
package asrp_pkg;

	// ----------------------------------------------------------------
	// frame layout
	// ----------------------------------------------------------------
	localparam int RESULT_BITS = 12;
	localparam int PAD_BITS    = 4;
	localparam int FRAME_BITS  = RESULT_BITS + PAD_BITS;
	localparam int COUNT_BITS  = 5;
	localparam int FIFO_DEPTH  = 4;

	localparam logic [COUNT_BITS-1:0] LAST_FALL  = 5'h0f;
	localparam logic [COUNT_BITS-1:0] COUNT_ZERO = 5'h00;
	localparam logic [COUNT_BITS-1:0] COUNT_STEP = 5'h01;
	localparam logic [PAD_BITS-1:0]   PAD_VALUE  = 4'h0;
	localparam logic [RESULT_BITS-1:0] EMPTY_CODE = 12'h000;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic cs_n;
		logic frame_sync;
		logic sclk;
	} asrp_link_type;

	// unipolar straight binary: 000 at ground, fff at full scale
	typedef struct packed {
		logic [RESULT_BITS-1:0] code;
	} asrp_result_type;

	typedef enum logic {
		st_idle,
		st_shift
	} asrp_state_type;

endpackage

// >>> asrp_port.sv
// serial result port: framing, shift-out and power state of the converter
//
// How it works
// - four wires: chip select low, frame sync, serial clock in, tristate data
// - each counted serial clock fall ticks the converter core
// - every frame carries one 12-bit result taken from the buffer, or code 000 when it is empty
// - outside a frame the port reports automatic power-down
// - data line floats until chip select falls or frame sync rises with chip select low
// - result leaves most significant bit first
// - a frame sync rise with chip select low marks the start of a frame
// - frame sync high at chip select fall: msb valid first clock fall
// - frame sync low at chip select fall: msb still presented
// - chip select low: frame sync rise presents msb, counts after it
// - code is straight binary, passed through unchanged
// - data changes on serial clock rises, host samples on falls
`timescale 1ns/1ps
module asrp_port (
	input  wire logic                    clock,
	input  wire logic                    rst,
	input  wire asrp_pkg::asrp_link_type link,
	output logic                         sdo,
	output logic                         sdo_oe,
	output logic                         power_down,
	output logic                         conv_tick,
	input  wire asrp_pkg::asrp_result_type result,
	input  wire logic                    result_valid,
	output logic                         result_ready
);
	// the serial clock is sampled, so it must stay well below clock / 4;
	// the full 20 MHz link rate needs a faster system clock

	asrp_pkg::asrp_link_type        sync_a;
	asrp_pkg::asrp_link_type        sync_b;
	asrp_pkg::asrp_link_type        sync_c;

	asrp_pkg::asrp_state_type       state;
	asrp_pkg::asrp_state_type       next_state;
	logic [asrp_pkg::FRAME_BITS-1:0] shift;
	logic [asrp_pkg::FRAME_BITS-1:0] next_shift;
	logic [asrp_pkg::COUNT_BITS-1:0] fall_count;
	logic [asrp_pkg::COUNT_BITS-1:0] next_fall_count;
	logic                           armed;
	logic                           next_armed;
	logic                           gate_fs;
	logic                           next_gate_fs;
	logic                           next_sdo;
	logic                           next_sdo_oe;
	logic                           next_conv_tick;

	logic                           sclk_rise;
	logic                           sclk_fall;
	logic                           cs_fall;
	logic                           fs_rise;
	logic                           start;
	logic                           counted_fall;
	logic [asrp_pkg::FRAME_BITS-1:0] load_word;

	logic                           fifo_valid;
	logic                           fifo_ready;
	asrp_pkg::asrp_result_type      fifo_data;

	// ----------------------------------------------------------------
	// result buffer
	// ----------------------------------------------------------------
	asrp_fifo #(
		.WIDTH (asrp_pkg::RESULT_BITS),
		.DEPTH (asrp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.rst       (rst),
		.in_valid  (result_valid),
		.in_data   (result.code),
		.in_ready  (result_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_data.code),
		.out_ready (fifo_ready)
	);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// sync_c only delays sync_b so edges never look at the first stage
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync_a <= '{cs_n: 1'b1, frame_sync: 1'b1, sclk: 1'b0};
			sync_b <= '{cs_n: 1'b1, frame_sync: 1'b1, sclk: 1'b0};
			sync_c <= '{cs_n: 1'b1, frame_sync: 1'b1, sclk: 1'b0};
		end else begin
			sync_a <= link;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	// ----------------------------------------------------------------
	// edge detection and framing
	// ----------------------------------------------------------------
	always_comb begin
		sclk_rise = sync_b.sclk && !sync_c.sclk;
		sclk_fall = !sync_b.sclk && sync_c.sclk;
		cs_fall   = !sync_b.cs_n && sync_c.cs_n;
		fs_rise   = sync_b.frame_sync && !sync_c.frame_sync;
		start = (state == asrp_pkg::st_idle) && armed &&
			(cs_fall || (fs_rise && !sync_b.cs_n));
		counted_fall = sclk_fall && !(gate_fs && sync_b.frame_sync);
		load_word = {fifo_valid ? fifo_data.code : asrp_pkg::EMPTY_CODE,
			asrp_pkg::PAD_VALUE};
		fifo_ready = start;
	end

	// ----------------------------------------------------------------
	// frame sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state      = state;
		next_shift      = shift;
		next_fall_count = fall_count;
		next_armed      = armed;
		next_gate_fs    = gate_fs;
		next_sdo        = sdo;
		next_sdo_oe     = sdo_oe;
		next_conv_tick  = 1'b0;
		case (state)
			asrp_pkg::st_idle: begin
				next_sdo_oe = 1'b0;
				if (sclk_fall) begin
					next_armed = 1'b1;
				end
				if (start) begin
					next_state      = asrp_pkg::st_shift;
					next_shift      = load_word;
					next_fall_count = asrp_pkg::COUNT_ZERO;
					next_armed      = 1'b0;
					// fs low at cs fall gates the count
					next_gate_fs    = cs_fall ? !sync_b.frame_sync : 1'b1;
					next_sdo        = load_word[asrp_pkg::FRAME_BITS-1];
					next_sdo_oe     = 1'b1;
				end
			end
			asrp_pkg::st_shift: begin
				if (sync_b.cs_n && !gate_fs) begin
					next_state  = asrp_pkg::st_idle;
					next_sdo_oe = 1'b0;
				end else if (counted_fall) begin
					next_conv_tick  = 1'b1;
					next_fall_count = fall_count + asrp_pkg::COUNT_STEP;
					if (fall_count == asrp_pkg::LAST_FALL) begin
						next_state  = asrp_pkg::st_idle;
						next_sdo_oe = 1'b0;
						next_armed  = 1'b1;
					end
				end else if (sclk_rise &&
						fall_count != asrp_pkg::COUNT_ZERO) begin
					next_shift = {shift[asrp_pkg::FRAME_BITS-2:0], 1'b0};
					next_sdo   = shift[asrp_pkg::FRAME_BITS-2];
				end
			end
			default: begin
				next_state  = asrp_pkg::st_idle;
				next_sdo_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state      <= asrp_pkg::st_idle;
			shift      <= '0;
			fall_count <= asrp_pkg::COUNT_ZERO;
			armed      <= 1'b0;
			gate_fs    <= 1'b0;
			sdo        <= 1'b0;
			sdo_oe     <= 1'b0;
			conv_tick  <= 1'b0;
			power_down <= 1'b1;
		end else begin
			state      <= next_state;
			shift      <= next_shift;
			fall_count <= next_fall_count;
			armed      <= next_armed;
			gate_fs    <= next_gate_fs;
			sdo        <= next_sdo;
			sdo_oe     <= next_sdo_oe;
			conv_tick  <= next_conv_tick;
			power_down <= next_state == asrp_pkg::st_idle;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_start;
		start;
	endsequence

	sequence s_last_fall;
		state == asrp_pkg::st_shift && !(sync_b.cs_n && !gate_fs) &&
			counted_fall && fall_count == asrp_pkg::LAST_FALL;
	endsequence

	sequence s_fs_start;
		state == asrp_pkg::st_idle && armed && fs_rise &&
			!sync_b.cs_n && !cs_fall;
	endsequence

	idle_float_a: assert property (power_down |-> !sdo_oe)
		else $error("data line driven while idle");

	msb_first_a: assert property (
		s_start |=> sdo_oe &&
		sdo == $past(load_word[asrp_pkg::FRAME_BITS-1]))
		else $error("msb not presented at frame start");

	// buffered code is the frame word
	code_load_a: assert property (
		s_start ##0 fifo_valid |=>
		shift[asrp_pkg::FRAME_BITS-1:asrp_pkg::PAD_BITS] ==
		$past(fifo_data.code))
		else $error("frame word differs from buffered result");

	rise_shift_a: assert property (
		(state == asrp_pkg::st_shift && sclk_rise && !sclk_fall &&
		!(sync_b.cs_n && !gate_fs) && fall_count != asrp_pkg::COUNT_ZERO)
		|=> sdo == $past(shift[asrp_pkg::FRAME_BITS-2]))
		else $error("data did not advance on clock rise");

	frame_end_a: assert property (
		s_last_fall |=> !sdo_oe ##0 power_down ##0 conv_tick)
		else $error("frame did not end after sixteen clocks");

	// chip select high releases the line unless fs gates the frame
	cs_release_a: assert property (
		(state == asrp_pkg::st_shift && sync_b.cs_n && !gate_fs)
		|=> !sdo_oe ##1 !sdo_oe)
		else $error("line still driven after chip select high");

	tick_fall_a: assert property (
		conv_tick |-> $past(sclk_fall) && $past(state) == asrp_pkg::st_shift)
		else $error("converter tick without a clock fall");

	// frame sync rise with chip select low starts a frame
	fs_start_a: assert property (s_fs_start |=> sdo_oe && !power_down)
		else $error("frame sync rise did not start a frame");

	// no count while frame sync gates it
	fs_gate_a: assert property (
		(state == asrp_pkg::st_shift && gate_fs && sync_b.frame_sync &&
		!sync_b.cs_n) |=> $stable(fall_count))
		else $error("clock fall counted while frame sync high");

	// drive starts only with a frame
	oe_start_a: assert property ($rose(sdo_oe) |-> $past(start))
		else $error("data line driven without a frame start");

	sdo_hold_a: assert property (
		state == asrp_pkg::st_shift && !sclk_rise |=> $stable(sdo))
		else $error("data changed without a clock rise");

	// count never passes the last fall
	count_bound_a: assert property (
		state == asrp_pkg::st_shift |->
		fall_count <= asrp_pkg::LAST_FALL)
		else $error("fall count ran past the frame");

	// cs fall with fs high counts at once
	cs_mode_a: assert property (
		s_start ##0 (cs_fall && sync_b.frame_sync) |=> !gate_fs)
		else $error("chip select frame gated by frame sync");

	// cs fall with fs low skips falls while fs is high
	cs_gate_a: assert property (
		s_start ##0 (cs_fall && !sync_b.frame_sync) |=> gate_fs)
		else $error("frame sync low at chip select not gated");

	frame_wake_a: assert property (s_start |=> !power_down)
		else $error("still powered down in a frame");

	empty_code_a: assert property (
		s_start ##0 !fifo_valid |=>
		shift[asrp_pkg::FRAME_BITS-1:asrp_pkg::PAD_BITS] ==
		asrp_pkg::EMPTY_CODE)
		else $error("empty buffer did not send code zero");

endmodule
